//--- hdl/hci_host_cmd_if.sv
// command entry front end: parallel handshake, serial link, rate selection, clear-to-send
// How it works
// [R01] host checks acknowledge is high before offering a character
// [R02] host drives all eight data lines before requesting
// [R03] host pulls request low once data is stable
// [R04] device pulls acknowledge low after capturing the character
// [R05] host then releases data and raises request, repeating per character
// [R06] acknowledge stays low while the command executes, possibly seconds
// [R07] acknowledge low at power-up selects fixed serial rate, no handshake
// [R08] fixed mode: request floating 9600, high 2400, low 300 baud
// [R09] fixed rates derive from the clock and scale with it
// [R10] mode command picks one of nine rates or adaptive rate
// [R11] acknowledge floating at power-up: device drives it, adaptive rate
// [R12] adaptive rate unknown until two carriage returns arrive after restart
// [R13] rate learner locks from 300 up to 76800 baud
// [R14] serial frame is eight data bits, no parity, one stop
// [R15] host withholds serial characters while clear-to-send is high
// [R16] clear-to-send high while processing, low again when ready
// [R17] clear-to-send shares user bit six, off at restart, mode bit five enables
// [R18] acknowledge returns high once execution has finished
`timescale 1ns/1ps
`include "hci_defs.svh"
module hci_host_cmd_if (
  input wire logic ref_clk_i, // 100 MHz reference clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [11:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error on unmapped address
  input wire logic io_request_n_i, // parallel request strobe, active low
  input wire logic req_float_i, // request pin seen floating by the pad
  input wire logic busy_n_i, // acknowledge pin level
  input wire logic busy_float_i, // acknowledge pin seen floating by the pad
  output logic busy_n_o, // acknowledge drive value, low = occupied
  output logic busy_n_oe_o, // acknowledge drive enable
  input wire logic [7:0] pbus_i, // parallel data bus
  input wire logic rxd_i, // serial in
  output logic txd_o, // serial out
  output logic user_bit_six_o, // clear-to-send, low = ready
  output logic user_bit_six_oe_o, // clear-to-send drive enable
  output logic cmd_valid_o, // one-cycle pulse per command character
  output logic [7:0] cmd_data_o, // command character
  output logic cmd_serial_o, // character came from the serial link
  input wire logic exec_busy_i // command interpreter still executing
);
  logic soft_rst_q, soft_rst_d, rst_all, strap_done_q, fixed_q, fixed_d, cts_en_q, cts_en_d;
  hci_pkg::hci_sel_t sel_q, sel_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] tx_byte_q, tx_byte_d;
  logic tx_go_q, tx_go_d, tx_busy, rx_valid, uart_en;
  logic [7:0] rx_data;
  hci_pkg::hci_div_t div;
  hci_pkg::hci_par_st_t par_q, par_d;
  logic par_take, ser_pend_q, ser_pend_d, ser_hold_q, ser_hold_d, ser_deliver;
  logic cmd_valid_q, cmd_valid_d, cmd_serial_q, cmd_serial_d;
  logic [7:0] cmd_data_q, cmd_data_d, ser_data_q, ser_data_d;
  hci_pkg::hci_learn_st_t ln_q, ln_d;
  logic [23:0] cnt_q, cnt_d;
  hci_pkg::hci_div_t first_q, first_d, learned_q, learned_d, width;
  logic have_q, have_d, lock_q, lock_d, pend_q, pend_d, rx_prev_q;
  logic apb_wr, apb_setup;

  function automatic hci_pkg::hci_div_t div_of(input hci_pkg::hci_sel_t s);
    case (s)
      4'h0: div_of = 20'(`HCI_DIV_300);
      4'h1: div_of = 20'(`HCI_DIV_600);
      4'h2: div_of = 20'(`HCI_DIV_1200);
      4'h3: div_of = 20'(`HCI_DIV_2400);
      4'h4: div_of = 20'(`HCI_DIV_4800);
      4'h5: div_of = 20'(`HCI_DIV_9600);
      4'h6: div_of = 20'(`HCI_DIV_19200);
      4'h7: div_of = 20'(`HCI_DIV_38400);
      default: div_of = 20'(`HCI_DIV_57600);
    endcase
  endfunction

  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == `HCI_OFS_CTRL) || (a == `HCI_OFS_MODE) || (a == `HCI_OFS_STAT) ||
              (a == `HCI_OFS_RXD) || (a == `HCI_OFS_TXD) || (a == `HCI_OFS_DIV);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // apb slave, mode register, restart and strap capture
  assign pready_o = 1'b1;
  assign apb_setup = psel_i && !penable_i;
  assign apb_wr = psel_i && penable_i && pwrite_i && reg_hit(paddr_i);
  assign pslverr_o = psel_i && penable_i && !reg_hit(paddr_i);
  assign rst_all = reset_i || soft_rst_q;

  always_comb begin
    soft_rst_d = apb_wr && (paddr_i == `HCI_OFS_CTRL) && pwdata_i[`HCI_CTRL_SRST_BIT];
    sel_d = sel_q;
    fixed_d = fixed_q;
    cts_en_d = cts_en_q;
    tx_byte_d = tx_byte_q;
    tx_go_d = 1'b0;
    prdata_d = prdata_q;
    if (!strap_done_q) begin
      // [R07] acknowledge strapped low: fixed rate
      fixed_d = !busy_n_i && !busy_float_i;
      // [R08] request strap picks the fixed rate
      if (!fixed_d) begin
        sel_d = `HCI_SEL_ADAPT;
      end else if (req_float_i) begin
        sel_d = `HCI_SEL_9600;
      end else if (io_request_n_i) begin
        sel_d = `HCI_SEL_2400;
      end else begin
        sel_d = `HCI_SEL_300;
      end
    end else if (apb_wr && paddr_i == `HCI_OFS_MODE) begin
      // [R10] nine rates or adaptive; other codes leave the rate alone
      if (pwdata_i[3:0] <= `HCI_SEL_ADAPT) begin
        sel_d = pwdata_i[3:0];
      end
      // [R17] mode bit five enables clear-to-send
      cts_en_d = pwdata_i[`HCI_MODE_CTS_BIT];
    end else if (apb_wr && paddr_i == `HCI_OFS_TXD && !tx_busy) begin
      tx_byte_d = pwdata_i[7:0];
      tx_go_d = 1'b1;
    end
    if (apb_setup) begin
      case (paddr_i)
        `HCI_OFS_MODE: prdata_d = {26'h000_0000, cts_en_q, 1'b0, sel_q};
        `HCI_OFS_STAT: prdata_d = {27'h000_0000, tx_busy, user_bit_six_o, busy_n_o, lock_q, fixed_q};
        `HCI_OFS_RXD: prdata_d = {24'h00_0000, ser_data_q};
        `HCI_OFS_TXD: prdata_d = {24'h00_0000, tx_byte_q};
        `HCI_OFS_DIV: prdata_d = {12'h000, div};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= soft_rst_d;
    end
    if (rst_all) begin
      strap_done_q <= 1'b0;
      fixed_q <= 1'b0;
      sel_q <= `HCI_SEL_ADAPT;
      cts_en_q <= 1'b0;
      tx_byte_q <= 8'h00;
      tx_go_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      strap_done_q <= 1'b1;
      fixed_q <= fixed_d;
      sel_q <= sel_d;
      cts_en_q <= cts_en_d;
      tx_byte_q <= tx_byte_d;
      tx_go_q <= tx_go_d;
      prdata_q <= prdata_d;
    end
  end
  assign prdata_o = prdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // rate learner: start bit of a carriage return is one bit period wide
  assign width = cnt_q[19:0];
  always_comb begin
    ln_d = ln_q;
    cnt_d = cnt_q;
    first_d = first_q;
    learned_d = learned_q;
    have_d = have_q;
    lock_d = lock_q;
    pend_d = pend_q;
    case (ln_q)
      hci_pkg::HCI_L_IDLE: begin
        if (strap_done_q && sel_q == `HCI_SEL_ADAPT && !lock_q && rx_prev_q && !rxd_i) begin
          cnt_d = 24'h00_0001;
          ln_d = hci_pkg::HCI_L_MEAS;
        end
      end
      hci_pkg::HCI_L_MEAS: begin
        if (!rxd_i) begin
          if (cnt_q < 24'(`HCI_LEARN_MAX_CYC)) begin
            cnt_d = cnt_q + 24'h00_0001;
          end
        // [R13] accept widths from 76800 to 300 baud
        end else if (cnt_q < 24'(`HCI_LEARN_MIN_CYC) || cnt_q >= 24'(`HCI_LEARN_MAX_CYC)) begin
          have_d = 1'b0;
          ln_d = hci_pkg::HCI_L_IDLE;
        end else begin
          // [R12] second matching carriage return locks the rate
          if (have_q && ((width > first_q) ? width - first_q : first_q - width) < (first_q >> 3)) begin
            learned_d = width;
            pend_d = 1'b1;
          end
          first_d = width;
          have_d = 1'b1;
          cnt_d = 24'h00_0000;
          ln_d = hci_pkg::HCI_L_SKIP;
        end
      end
      hci_pkg::HCI_L_SKIP: begin
        // rest of the character skipped up to mid stop bit
        cnt_d = cnt_q + 24'h00_0001;
        if (cnt_q >= ({4'h0, first_q} << 3) + {5'h00, first_q[19:1]}) begin
          lock_d = pend_q;
          pend_d = 1'b0;
          ln_d = hci_pkg::HCI_L_IDLE;
        end
      end
      default: ln_d = hci_pkg::HCI_L_IDLE;
    endcase
    if (strap_done_q && sel_q != `HCI_SEL_ADAPT) begin
      lock_d = 1'b0;
      have_d = 1'b0;
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_all) begin
      ln_q <= hci_pkg::HCI_L_IDLE;
      cnt_q <= 24'h00_0000;
      first_q <= 20'h0_0000;
      learned_q <= 20'h0_0001;
      have_q <= 1'b0;
      lock_q <= 1'b0;
      pend_q <= 1'b0;
      rx_prev_q <= 1'b1;
    end else begin
      ln_q <= ln_d;
      cnt_q <= cnt_d;
      first_q <= first_d;
      learned_q <= learned_d;
      have_q <= have_d;
      lock_q <= lock_d;
      pend_q <= pend_d;
      rx_prev_q <= rxd_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial link
  // [R09] periods follow the reference clock, so rates track its frequency
  assign div = (sel_q == `HCI_SEL_ADAPT) ? learned_q : div_of(sel_q);
  assign uart_en = strap_done_q && (sel_q != `HCI_SEL_ADAPT || lock_q);

  hci_uart_core u_uart (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_all),
    .en_i(uart_en),
    .div_i(div),
    .rxd_i(rxd_i),
    .rx_valid_o(rx_valid),
    .rx_data_o(rx_data),
    .tx_go_i(tx_go_q),
    .tx_data_i(tx_byte_q),
    .tx_busy_o(tx_busy),
    .txd_o(txd_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // parallel handshake and character delivery
  assign par_take = strap_done_q && !fixed_q && par_q == hci_pkg::HCI_P_IDLE && !io_request_n_i;
  // parallel wins a same-cycle tie; the serial byte waits one cycle
  assign ser_deliver = ser_pend_q && !par_take;

  always_comb begin
    par_d = par_q;
    case (par_q)
      hci_pkg::HCI_P_IDLE: begin
        if (par_take) begin
          par_d = hci_pkg::HCI_P_SET;
        end
      end
      // one cycle for the interpreter to raise exec_busy_i
      hci_pkg::HCI_P_SET: par_d = hci_pkg::HCI_P_HOLD;
      hci_pkg::HCI_P_HOLD: begin
        // [R18] release after request back high and execution done
        if (io_request_n_i && !exec_busy_i) begin
          par_d = hci_pkg::HCI_P_IDLE;
        end
      end
      default: par_d = hci_pkg::HCI_P_IDLE;
    endcase
    cmd_valid_d = par_take || ser_deliver;
    cmd_data_d = par_take ? pbus_i : (ser_deliver ? ser_data_q : cmd_data_q);
    cmd_serial_d = par_take ? 1'b0 : (ser_deliver ? 1'b1 : cmd_serial_q);
    // set wins over delivery
    ser_pend_d = rx_valid || (ser_pend_q && !ser_deliver);
    ser_data_d = rx_valid ? rx_data : ser_data_q;
    ser_hold_d = ser_deliver || (ser_hold_q && (exec_busy_i || cmd_valid_q));
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_all) begin
      par_q <= hci_pkg::HCI_P_IDLE;
      cmd_valid_q <= 1'b0;
      cmd_data_q <= 8'h00;
      cmd_serial_q <= 1'b0;
      ser_pend_q <= 1'b0;
      ser_data_q <= 8'h00;
      ser_hold_q <= 1'b0;
    end else begin
      par_q <= par_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_data_q <= cmd_data_d;
      cmd_serial_q <= cmd_serial_d;
      ser_pend_q <= ser_pend_d;
      ser_data_q <= ser_data_d;
      ser_hold_q <= ser_hold_d;
    end
  end

  // [R04] acknowledge low from capture until release
  assign busy_n_o = (par_q == hci_pkg::HCI_P_IDLE);
  // [R11] drive acknowledge only once it was read as not strapped low
  assign busy_n_oe_o = strap_done_q && !fixed_q;
  // [R16] clear-to-send high while a serial character is in process
  assign user_bit_six_o = ser_pend_q || ser_hold_q;
  assign user_bit_six_oe_o = cts_en_q;
  assign cmd_valid_o = cmd_valid_q;
  assign cmd_data_o = cmd_data_q;
  assign cmd_serial_o = cmd_serial_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_ack_on_take: assert property (par_take && !soft_rst_q |=> !busy_n_o ##1 !busy_n_o) // [R04]
    else $error("acknowledge not low after capture");
  a_ack_during_exec: assert property (par_q == hci_pkg::HCI_P_HOLD && exec_busy_i && !soft_rst_q |=> !busy_n_o) // [R06]
    else $error("acknowledge released while executing");
  a_ack_release: assert property (par_q == hci_pkg::HCI_P_HOLD && io_request_n_i && !exec_busy_i |=> busy_n_o) // [R18]
    else $error("acknowledge not released after execution");
  a_fixed_no_drive: assert property (fixed_q |-> !busy_n_oe_o) // [R07]
    else $error("acknowledge driven in fixed rate mode");
  a_strap_rate: assert property (!strap_done_q && !soft_rst_q && !busy_n_i && !busy_float_i |=> // [R08]
    fixed_q && sel_q == ($past(req_float_i) ? `HCI_SEL_9600 : ($past(io_request_n_i) ? `HCI_SEL_2400 : `HCI_SEL_300)))
    else $error("fixed rate strap decoded wrongly");
  a_adapt_default: assert property (!strap_done_q && !soft_rst_q && busy_float_i |=> // [R11]
    busy_n_oe_o && sel_q == `HCI_SEL_ADAPT && !lock_q)
    else $error("floating acknowledge did not select adaptive mode");
  a_adapt_gate: assert property (sel_q == `HCI_SEL_ADAPT && !lock_q |-> !uart_en) // [R12]
    else $error("serial link open before rate was learned");
  a_rate_period: assert property (strap_done_q && sel_q == `HCI_SEL_300 |-> div == 20'(`HCI_CLK_HZ / 300)) // [R09]
    else $error("bit period does not follow the reference clock");
  a_cts_restart: assert property (soft_rst_q |=> !user_bit_six_oe_o ##1 !user_bit_six_oe_o) // [R17]
    else $error("clear-to-send enabled after restart");
  a_cts_busy: assert property (ser_deliver && !soft_rst_q |=> user_bit_six_o) // [R16]
    else $error("clear-to-send not inactive while processing");

  c_par_char: cover property (par_take ##1 !busy_n_o ##[1:20] busy_n_o);
  c_rate_lock: cover property (!lock_q ##1 lock_q);
  c_ser_cts: cover property (cts_en_q && ser_deliver ##1 user_bit_six_o);
endmodule

//--- hdl/hci_defs.svh
// offsets, field positions, rate codes and timing counts of the host command interface
`ifndef HCI_DEFS_SVH
`define HCI_DEFS_SVH

`define HCI_CLK_HZ 100000000
`define HCI_XTAL_REF_HZ 11000000

// register byte offsets
`define HCI_OFS_CTRL 12'h000
`define HCI_OFS_MODE 12'h004
`define HCI_OFS_STAT 12'h008
`define HCI_OFS_RXD 12'h00C
`define HCI_OFS_TXD 12'h010
`define HCI_OFS_DIV 12'h014

// field positions
`define HCI_CTRL_SRST_BIT 0
`define HCI_MODE_CTS_BIT 5
`define HCI_STAT_FIXED_BIT 0
`define HCI_STAT_LOCK_BIT 1
`define HCI_STAT_ACK_BIT 2
`define HCI_STAT_CTS_BIT 3
`define HCI_STAT_TXB_BIT 4

// rate selections; codes 0..8 index the rate table
`define HCI_SEL_300 4'h0
`define HCI_SEL_2400 4'h3
`define HCI_SEL_9600 4'h5
`define HCI_SEL_ADAPT 4'h9

// bit periods in reference clocks
`define HCI_DIV_300 (`HCI_CLK_HZ / 300)
`define HCI_DIV_600 (`HCI_CLK_HZ / 600)
`define HCI_DIV_1200 (`HCI_CLK_HZ / 1200)
`define HCI_DIV_2400 (`HCI_CLK_HZ / 2400)
`define HCI_DIV_4800 (`HCI_CLK_HZ / 4800)
`define HCI_DIV_9600 (`HCI_CLK_HZ / 9600)
`define HCI_DIV_19200 (`HCI_CLK_HZ / 19200)
`define HCI_DIV_38400 (`HCI_CLK_HZ / 38400)
`define HCI_DIV_57600 (`HCI_CLK_HZ / 57600)

// width window the rate learner accepts: 76800 down to 300 baud, 1/8 slack
`define HCI_LEARN_MIN_CYC ((`HCI_CLK_HZ / 76800) * 7 / 8)
`define HCI_LEARN_MAX_CYC ((`HCI_CLK_HZ / 300) * 9 / 8)

`endif

//--- hdl/hci_pkg.sv
// types of the host command interface
package hci_pkg;
  typedef logic [3:0] hci_sel_t;
  typedef logic [19:0] hci_div_t;
  typedef enum logic [1:0] {
    HCI_P_IDLE = 2'b00,
    HCI_P_SET = 2'b01,
    HCI_P_HOLD = 2'b11
  } hci_par_st_t;
  typedef enum logic [1:0] {
    HCI_L_IDLE = 2'b00,
    HCI_L_MEAS = 2'b01,
    HCI_L_SKIP = 2'b11
  } hci_learn_st_t;
endpackage

//--- hdl/hci_uart_core.sv
// 8N1 serial receiver and transmitter with a run-time bit period
`timescale 1ns/1ps
module hci_uart_core (
  input wire logic ref_clk_i, // reference clock
  input wire logic rst_i, // restart, active high
  input wire logic en_i, // rate known, link usable
  input wire logic [19:0] div_i, // bit period in clocks
  input wire logic rxd_i, // serial line in
  output logic rx_valid_o, // one-cycle pulse per good frame
  output logic [7:0] rx_data_o, // last received byte
  input wire logic tx_go_i, // start sending tx_data_i
  input wire logic [7:0] tx_data_i, // byte to send
  output logic tx_busy_o, // frame in flight
  output logic txd_o // serial line out
);
  logic r_act_q, r_act_d, r_prev_q, rx_valid_q, rx_valid_d;
  logic [19:0] r_cnt_q, r_cnt_d;
  logic [3:0] r_bit_q, r_bit_d;
  logic [7:0] r_sh_q, r_sh_d, rx_data_q, rx_data_d;
  logic t_act_q, t_act_d, t_line_q, t_line_d;
  logic [19:0] t_cnt_q, t_cnt_d;
  logic [3:0] t_bit_q, t_bit_d;
  logic [9:0] t_sh_q, t_sh_d;

  //////////////////////////////////////////////////////////////////////////////
  // receiver: centre sampling, start, 8 data lsb first, one stop
  always_comb begin
    r_act_d = r_act_q;
    r_cnt_d = r_cnt_q;
    r_bit_d = r_bit_q;
    r_sh_d = r_sh_q;
    rx_data_d = rx_data_q;
    rx_valid_d = 1'b0;
    if (!r_act_q) begin
      if (en_i && r_prev_q && !rxd_i) begin
        r_act_d = 1'b1;
        r_cnt_d = {1'b0, div_i[19:1]};
        r_bit_d = 4'h0;
      end
    end else if (r_cnt_q != 20'h0_0000) begin
      r_cnt_d = r_cnt_q - 20'h0_0001;
    end else begin
      r_cnt_d = div_i - 20'h0_0001;
      r_bit_d = r_bit_q + 4'h1;
      // [R14] no parity, one stop
      if (r_bit_q == 4'h0) begin
        // glitch, not a start bit
        if (rxd_i) begin
          r_act_d = 1'b0;
        end
      end else if (r_bit_q == 4'h9) begin
        r_act_d = 1'b0;
        // framing error: byte dropped
        if (rxd_i) begin
          rx_valid_d = 1'b1;
          rx_data_d = r_sh_q;
        end
      end else begin
        r_sh_d = {rxd_i, r_sh_q[7:1]};
      end
    end
    if (!en_i) begin
      r_act_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r_act_q <= 1'b0;
      r_prev_q <= 1'b1;
      r_cnt_q <= 20'h0_0000;
      r_bit_q <= 4'h0;
      r_sh_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      r_act_q <= r_act_d;
      r_prev_q <= rxd_i;
      r_cnt_q <= r_cnt_d;
      r_bit_q <= r_bit_d;
      r_sh_q <= r_sh_d;
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmitter
  always_comb begin
    t_act_d = t_act_q;
    t_line_d = t_line_q;
    t_cnt_d = t_cnt_q;
    t_bit_d = t_bit_q;
    t_sh_d = t_sh_q;
    if (!t_act_q) begin
      if (tx_go_i && en_i) begin
        t_act_d = 1'b1;
        t_sh_d = {1'b1, tx_data_i, 1'b0};
        t_line_d = 1'b0;
        t_bit_d = 4'h0;
        t_cnt_d = div_i - 20'h0_0001;
      end
    end else if (t_cnt_q != 20'h0_0000) begin
      t_cnt_d = t_cnt_q - 20'h0_0001;
    end else if (t_bit_q == 4'h9) begin
      t_act_d = 1'b0;
      t_line_d = 1'b1;
    end else begin
      t_sh_d = {1'b1, t_sh_q[9:1]};
      t_line_d = t_sh_q[1];
      t_bit_d = t_bit_q + 4'h1;
      t_cnt_d = div_i - 20'h0_0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      t_act_q <= 1'b0;
      t_line_q <= 1'b1;
      t_cnt_q <= 20'h0_0000;
      t_bit_q <= 4'h0;
      t_sh_q <= 10'h3FF;
    end else begin
      t_act_q <= t_act_d;
      t_line_q <= t_line_d;
      t_cnt_q <= t_cnt_d;
      t_bit_q <= t_bit_d;
      t_sh_q <= t_sh_d;
    end
  end

  assign rx_valid_o = rx_valid_q;
  assign rx_data_o = rx_data_q;
  assign tx_busy_o = t_act_q;
  assign txd_o = t_line_q;

  a_tx_start_bit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_go_i && en_i && !t_act_q) |=> (!txd_o && tx_busy_o)) // [R14]
    else $error("tx frame did not open with a start bit");
endmodule

//--- sim/hci_host_model.sv
// host side partner: parallel handshake and 8n1 serial sender
`timescale 1ns/1ps
module hci_host_model (
  input wire logic ref_clk_i, // clock
  input wire logic busy_n_i, // acknowledge pin level
  output logic io_request_n_o, // request strobe
  output logic [7:0] pbus_o, // parallel data
  output logic rxd_o // serial line to device
);
  initial begin
    io_request_n_o = 1'b1;
    pbus_o = 8'h00;
    rxd_o = 1'b1;
  end
  task automatic par_send(input logic [7:0] b, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 50 && busy_n_i !== 1'b1; n++) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    // data a cycle ahead of strobe
    pbus_o <= b;
    @(posedge ref_clk_i);
    io_request_n_o <= 1'b0;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(negedge ref_clk_i);
      ok = (busy_n_i === 1'b0);
    end
    @(posedge ref_clk_i);
    // released bus shows stale inverse, not the old byte
    pbus_o <= ~b;
    io_request_n_o <= 1'b1;
  endtask
  task automatic ser_send(input logic [7:0] b, input int div);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    // start, data lsb first, one stop
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (div) @(posedge ref_clk_i);
    end
  endtask
endmodule

//--- sim/tb_top.sv
// self-checking bench for the host command interface
`timescale 1ns/1ps
`include "hci_defs.svh"
module tb_top;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e; logic s;} hci_row_t;
  logic ref_clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, req_float_i, busy_float_i;
  logic busy_lvl, req_en, req_lvl, host_req_n, busy_n_o, busy_n_oe_o, rxd, txd_o, err, ok, got_ser;
  logic user_bit_six_o, user_bit_six_oe_o, cmd_valid_o, cmd_serial_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [7:0] pbus, cmd_data_o, got;
  int n_errors = 0;
  int samples_checked = 0;
  int exec_cnt = 0;
  int fdiv[3] = '{`HCI_CLK_HZ / 9600, `HCI_CLK_HZ / 2400, `HCI_CLK_HZ / 300};
  hci_row_t rows[8] = '{'{12'h008, 1'b0, '0, 32'h0000_0006, 1'b0}, '{12'h014, 1'b0, '0, `HCI_CLK_HZ / 57600, 1'b0},
    '{12'h004, 1'b1, 32'h0000_0028, '0, 1'b0}, '{12'h004, 1'b0, '0, 32'h0000_0028, 1'b0},
    '{12'h014, 1'b0, '0, `HCI_CLK_HZ / 57600, 1'b0}, '{12'h018, 1'b0, '0, '0, 1'b1},
    '{12'h01C, 1'b1, 32'h0000_0055, '0, 1'b1}, '{12'h000, 1'b0, '0, '0, 1'b0}};
  wire busy_pin = busy_n_oe_o ? busy_n_o : busy_lvl;
  wire io_req_n = req_en ? req_lvl : host_req_n;
  wire exec_busy = exec_cnt != 0;
  hci_host_cmd_if dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .io_request_n_i(io_req_n), .req_float_i(req_float_i), .busy_n_i(busy_pin),
    .busy_float_i(busy_float_i), .busy_n_o(busy_n_o), .busy_n_oe_o(busy_n_oe_o), .pbus_i(pbus), .rxd_i(rxd),
    .txd_o(txd_o), .user_bit_six_o(user_bit_six_o), .user_bit_six_oe_o(user_bit_six_oe_o),
    .cmd_valid_o(cmd_valid_o), .cmd_data_o(cmd_data_o), .cmd_serial_o(cmd_serial_o), .exec_busy_i(exec_busy));
  hci_host_model host (.ref_clk_i(ref_clk_i), .busy_n_i(busy_pin), .io_request_n_o(host_req_n),
    .pbus_o(pbus), .rxd_o(rxd));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // interpreter stand-in: busy for 1000 cycles per character
  always @(posedge ref_clk_i) begin
    if (cmd_valid_o === 1'b1) begin
      got <= cmd_data_o;
      got_ser <= cmd_serial_o;
      exec_cnt <= 1000;
    end else if (exec_cnt != 0) begin
      exec_cnt <= exec_cnt - 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input bit c, input string m);
    samples_checked++;
    if (!c) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (pready_o === 1'b1) break;
    end
    chk(pready_o === 1'b1, "no pready");
    err = pslverr_o;
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {reset_i, busy_float_i, busy_lvl, req_float_i, req_lvl} = '1;
    req_en = 1'b0;
    repeat (16) @(posedge ref_clk_i);
    chk(busy_n_oe_o === 1'b0 && user_bit_six_oe_o === 1'b0, "reset drive");
    reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(busy_n_oe_o === 1'b1 && busy_n_o === 1'b1, "ack idle");
    // adaptive rate: two carriage returns first, then the first two rows expect lock and the learned period
    repeat (2) host.ser_send(8'h0D, `HCI_CLK_HZ / 57600);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      chk(err === rows[i].s && (rows[i].w || rd === rows[i].e), "register row");
    end
    $display("test registers done");
    host.par_send(8'h47, ok);
    repeat (2) @(posedge ref_clk_i);
    chk(ok === 1'b1 && got === 8'h47 && got_ser === 1'b0, "parallel char");
    repeat (10) @(posedge ref_clk_i);
    chk(busy_n_o === 1'b0, "ack held");
    for (int n = 0; n < 1200 && busy_n_o !== 1'b1; n++) @(negedge ref_clk_i);
    chk(busy_n_o === 1'b1 && exec_busy === 1'b0, "ack release");
    $display("test parallel done");
    // send only while clear-to-send is low
    for (int n = 0; n < 100 && user_bit_six_o !== 1'b0; n++) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    host.ser_send(8'hA5, `HCI_CLK_HZ / 57600);
    chk(got === 8'hA5 && got_ser === 1'b1 && user_bit_six_o === 1'b1 && user_bit_six_oe_o === 1'b1, "serial");
    for (int n = 0; n < 1200 && user_bit_six_o !== 1'b0; n++) @(negedge ref_clk_i);
    chk(user_bit_six_o === 1'b0, "cts ready");
    // transmit 0x55: start bit, then data bits 0 and 1, lsb first
    apb(12'h010, 1'b1, 32'h0000_0055);
    repeat (2) @(posedge ref_clk_i);
    for (int i = 0; i < 3; i++) begin
      chk(txd_o === i[0], "tx frame bit");
      repeat (`HCI_CLK_HZ / 57600) @(posedge ref_clk_i);
    end
    $display("test serial done");
    busy_float_i <= 1'b0;
    busy_lvl <= 1'b0;
    req_en <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      req_float_i <= (k == 0);
      req_lvl <= (k != 2);
      apb(12'h000, 1'b1, 32'h0000_0001);
      repeat (4) @(posedge ref_clk_i);
      apb(12'h014, 1'b0, '0);
      chk(rd === fdiv[k] && busy_n_oe_o === 1'b0 && user_bit_six_oe_o === 1'b0, "fixed rate");
    end
    $display("test fixed done");
    give_verdict();
  end
endmodule
